// File: hw/sdrwo_dma.sv
// DMA channel that runs read-only or write-only block transfers through the serial port.
`timescale 1ns/1ps
`include "sdrwo_consts.svh"
module sdrwo_dma
  import sdrwo_pkg::*;
#(
  parameter int DEPTH = 16
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  sdrwo_if.dma bus,
  input wire logic [2:0] sw_addr_in,
  input wire logic [7:0] sw_wdata_in,
  input wire logic sw_wr_in,
  input wire logic sw_rd_in,
  output logic [7:0] sw_rdata_out,
  output logic irq_out
);

  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH || AW > 8) begin : g_bad_depth
      $error("DEPTH must be a power of two from 2 to 256");
    end
  endgenerate

  function automatic logic sw_hit(input logic strobe, input logic [2:0] a,
                                  input logic [2:0] r);
    return strobe && (a == r);
  endfunction

  logic [7:0] mem [DEPTH];
  sdrwo_dma_st_type st_reg;
  logic wr_reg;
  logic rd_reg;
  sdrwo_addr_type addr_reg;
  sdrwo_byte_type wdata_reg;
  logic wo_reg;
  logic master_reg;
  logic [7:0] count_reg;
  logic [7:0] rem_reg;
  logic [AW-1:0] dptr_reg;
  logic [AW-1:0] sptr_reg;
  logic [1:0] stat_reg;
  logic [1:0] ien_reg;
  logic [7:0] rdata_reg;
  logic ev_done_reg;
  logic start;
  logic wo_move;
  logic [7:0] dev_ctrl;

  assign start = sw_hit(sw_wr_in, sw_addr_in, `SDRWO_HREG_CTRL)
                 && sw_wdata_in[`SDRWO_HCTRL_START] && st_reg == SDRWO_DS_IDLE
                 && count_reg != 8'h00;
  // Write-only moves one byte per transmit request; receive requests are ignored.
  assign wo_move = st_reg == SDRWO_DS_WAIT && wo_reg && bus.tx_done_req
                   && rem_reg != 8'h00;

  always_comb begin
    dev_ctrl = 8'h00;
    dev_ctrl[`SDRWO_CTRL_EN] = 1'b1;
    dev_ctrl[`SDRWO_CTRL_DMA] = 1'b1;
    dev_ctrl[`SDRWO_CTRL_MASTER] = master_reg;
    dev_ctrl[`SDRWO_CTRL_AUTO] = master_reg && !wo_reg;
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wo_reg <= 1'b0;
      master_reg <= 1'b0;
    end else if (start) begin
      wo_reg <= sw_wdata_in[`SDRWO_HCTRL_WO];
      master_reg <= sw_wdata_in[`SDRWO_HCTRL_MASTER];
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_reg <= SDRWO_DS_IDLE;
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
      addr_reg <= `SDRWO_REG_DATA;
      wdata_reg <= 8'h00;
      ev_done_reg <= 1'b0;
    end else begin
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
      ev_done_reg <= 1'b0;
      unique case (st_reg)
        SDRWO_DS_IDLE: begin
          if (start) begin
            st_reg <= SDRWO_DS_CFG;
          end
        end
        SDRWO_DS_CFG: begin
          wr_reg <= 1'b1;
          addr_reg <= `SDRWO_REG_CTRL;
          wdata_reg <= dev_ctrl;
          st_reg <= (wo_reg || master_reg) ? SDRWO_DS_KICK : SDRWO_DS_WAIT;
        end
        SDRWO_DS_KICK: begin
          wr_reg <= 1'b1;
          addr_reg <= `SDRWO_REG_DATA;
          wdata_reg <= wo_reg ? mem[dptr_reg] : 8'h00;
          st_reg <= SDRWO_DS_WAIT;
        end
        SDRWO_DS_WAIT: begin
          if (wo_move) begin
            wr_reg <= 1'b1;
            addr_reg <= `SDRWO_REG_DATA;
            wdata_reg <= mem[dptr_reg];
          end else if (wo_reg && bus.tx_done_req) begin
            ev_done_reg <= 1'b1;
            st_reg <= SDRWO_DS_IDLE;
          end else if (!wo_reg && bus.rx_done_req) begin
            rd_reg <= 1'b1;
            addr_reg <= `SDRWO_REG_DATA;
            st_reg <= SDRWO_DS_RD;
          end
        end
        SDRWO_DS_RD: begin
          st_reg <= SDRWO_DS_CAP;
        end
        SDRWO_DS_CAP: begin
          if (rem_reg == 8'h01) begin
            ev_done_reg <= 1'b1;
            st_reg <= SDRWO_DS_IDLE;
          end else begin
            st_reg <= SDRWO_DS_WAIT;
          end
        end
        default: begin
          st_reg <= SDRWO_DS_IDLE;
        end
      endcase
    end
  end

  // Each completed move steps the pointer and counts the block down.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rem_reg <= 8'h00;
      dptr_reg <= '0;
    end else if (start) begin
      rem_reg <= count_reg;
      dptr_reg <= '0;
    end else if ((st_reg == SDRWO_DS_KICK && wo_reg) || wo_move
                 || st_reg == SDRWO_DS_CAP) begin
      rem_reg <= rem_reg - 8'h01;
      dptr_reg <= dptr_reg + AW'(1);
    end
  end

  always_ff @(posedge clk_in) begin
    if (st_reg == SDRWO_DS_CAP) begin
      mem[dptr_reg] <= bus.rdata;
    end else if (sw_hit(sw_wr_in, sw_addr_in, `SDRWO_HREG_MEM)) begin
      mem[sptr_reg] <= sw_wdata_in;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      count_reg <= 8'h00;
      ien_reg <= 2'h0;
      sptr_reg <= '0;
    end else begin
      if (sw_hit(sw_wr_in, sw_addr_in, `SDRWO_HREG_COUNT)) begin
        count_reg <= sw_wdata_in;
      end
      if (sw_hit(sw_wr_in, sw_addr_in, `SDRWO_HREG_IEN)) begin
        ien_reg <= sw_wdata_in[1:0];
      end
      if (sw_hit(sw_wr_in, sw_addr_in, `SDRWO_HREG_PTR)) begin
        sptr_reg <= sw_wdata_in[AW-1:0];
      end else if (sw_hit(sw_wr_in, sw_addr_in, `SDRWO_HREG_MEM)) begin
        sptr_reg <= sptr_reg + AW'(1);
      end
    end
  end

  // Sticky events: a new event wins over a clear in the same cycle.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      stat_reg <= 2'h0;
    end else begin
      stat_reg <= (stat_reg & ~(sw_hit(sw_wr_in, sw_addr_in, `SDRWO_HREG_CLR)
                  ? sw_wdata_in[1:0] : 2'h0)) | {bus.error_req, ev_done_reg};
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_reg <= 8'h00;
    end else if (sw_rd_in) begin
      unique case (sw_addr_in)
        `SDRWO_HREG_CTRL: rdata_reg <= {st_reg != SDRWO_DS_IDLE, 4'h0, master_reg, wo_reg, 1'b0};
        `SDRWO_HREG_COUNT: rdata_reg <= rem_reg;
        `SDRWO_HREG_STAT: rdata_reg <= {6'h00, stat_reg};
        `SDRWO_HREG_IEN: rdata_reg <= {6'h00, ien_reg};
        `SDRWO_HREG_PTR: rdata_reg <= 8'(sptr_reg);
        `SDRWO_HREG_MEM: rdata_reg <= mem[sptr_reg];
        default: rdata_reg <= 8'h00;
      endcase
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  assign bus.wr = wr_reg;
  assign bus.rd = rd_reg;
  assign bus.addr = addr_reg;
  assign bus.wdata = wdata_reg;
  assign sw_rdata_out = rdata_reg;
  assign irq_out = |(stat_reg & ien_reg);

endmodule

// File: hw/sdrwo_port.sv
// Synchronous serial port with transfer-done flags that pace a DMA channel.
`timescale 1ns/1ps
`include "sdrwo_consts.svh"
module sdrwo_port
  import sdrwo_pkg::*;
#(
  parameter int SCK_HALF_NS = `SDRWO_SCK_HALF_NS
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  sdrwo_if.dev bus,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe_out,
  input wire logic sdi_in,
  output logic sdo_out,
  input wire logic ss_n_in
);

  localparam int HALF_CYC = (SCK_HALF_NS + `SDRWO_CLK_NS - 1) / `SDRWO_CLK_NS;
  localparam logic [7:0] HALF_LOAD = 8'(HALF_CYC - 1);

  generate
    if (HALF_CYC < 3 || HALF_CYC > 256) begin : g_bad_half
      $error("SCK_HALF_NS gives a half period the timer cannot count");
    end
  endgenerate

  function automatic logic reg_hit(input logic strobe, input sdrwo_addr_type a,
                                   input sdrwo_addr_type r);
    return strobe && (a == r);
  endfunction

  localparam logic [2:0] PIN_RST = `SDRWO_PIN_RST;
  logic [2:0] pins, pin_s1_reg, pin_s2_reg, pin_s3_reg, pin_lvl_reg;
  logic sck_prev_reg;
  logic [3:0] ctrl_reg;
  sdrwo_port_st_type state_reg, state_next;
  logic [7:0] tmr_reg;
  logic [3:0] cnt_reg;
  sdrwo_byte_type sh_reg, sh_next, rdata_reg;
  logic out_reg, sck_reg, rx_done_reg, tx_done_reg, ovf_reg;
  logic [2:0] flag_prev_reg;
  logic en, is_master, dma_mode, wr_data, rd_data, wr_stat, wr_ctrl, idle, wr_ok;
  logic auto_go, go_m, go_s, abort, tick, s_rise, s_fall, rise, fall, done;

  assign pins = {ss_n_in, sdi_in, sck_in};

  // Three-stage synchronisers; a level is taken only when stages two and three agree.
  generate
    for (genvar i = 0; i < 3; i++) begin : g_sync
      always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          pin_s1_reg[i] <= PIN_RST[i];
          pin_s2_reg[i] <= PIN_RST[i];
          pin_s3_reg[i] <= PIN_RST[i];
          pin_lvl_reg[i] <= PIN_RST[i];
        end else begin
          pin_s1_reg[i] <= pins[i];
          pin_s2_reg[i] <= pin_s1_reg[i];
          pin_s3_reg[i] <= pin_s2_reg[i];
          if (pin_s2_reg[i] == pin_s3_reg[i]) begin
            pin_lvl_reg[i] <= pin_s3_reg[i];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sck_prev_reg <= 1'b0;
    end else begin
      sck_prev_reg <= pin_lvl_reg[`SDRWO_PIN_SCK];
    end
  end

  assign en = ctrl_reg[`SDRWO_CTRL_EN];
  assign is_master = ctrl_reg[`SDRWO_CTRL_MASTER];
  assign dma_mode = ctrl_reg[`SDRWO_CTRL_DMA];
  assign wr_data = reg_hit(bus.wr, bus.addr, `SDRWO_REG_DATA);
  assign rd_data = reg_hit(bus.rd, bus.addr, `SDRWO_REG_DATA);
  assign wr_stat = reg_hit(bus.wr, bus.addr, `SDRWO_REG_STAT);
  assign wr_ctrl = reg_hit(bus.wr, bus.addr, `SDRWO_REG_CTRL);
  assign idle = (state_reg == SDRWO_ST_IDLE);
  // A slave may still load the shifter after select but before its first edge.
  assign wr_ok = idle || (!is_master && state_reg == SDRWO_ST_LOW && cnt_reg == 4'h0);
  assign auto_go = rd_data && idle && en && is_master && ctrl_reg[`SDRWO_CTRL_AUTO]
                   && dma_mode;
  assign go_m = idle && en && is_master && (wr_data || auto_go);
  assign go_s = idle && en && !is_master && !pin_lvl_reg[`SDRWO_PIN_SSN];
  assign abort = !idle && (!en || (!is_master && pin_lvl_reg[`SDRWO_PIN_SSN]));
  assign tick = (tmr_reg == 8'h00);
  assign s_rise = pin_lvl_reg[`SDRWO_PIN_SCK] && !sck_prev_reg;
  assign s_fall = !pin_lvl_reg[`SDRWO_PIN_SCK] && sck_prev_reg;
  assign rise = !abort && state_reg == SDRWO_ST_LOW && (is_master ? tick : s_rise);
  assign fall = !abort && state_reg == SDRWO_ST_HIGH && (is_master ? tick : s_fall);
  assign done = fall && (cnt_reg == `SDRWO_BITS);

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ctrl_reg <= 4'h0;
    end else if (wr_ctrl) begin
      ctrl_reg <= bus.wdata[3:0];
    end
  end

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      SDRWO_ST_IDLE: begin
        if (go_m || go_s) begin
          state_next = SDRWO_ST_LOW;
        end
      end
      SDRWO_ST_LOW: begin
        if (abort) begin
          state_next = SDRWO_ST_IDLE;
        end else if (rise) begin
          state_next = SDRWO_ST_HIGH;
        end
      end
      SDRWO_ST_HIGH: begin
        if (abort || done) begin
          state_next = SDRWO_ST_IDLE;
        end else if (fall) begin
          state_next = SDRWO_ST_LOW;
        end
      end
      default: begin
        state_next = SDRWO_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_reg <= SDRWO_ST_IDLE;
      sck_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      sck_reg <= is_master && (state_next == SDRWO_ST_HIGH);
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tmr_reg <= 8'h00;
      cnt_reg <= 4'h0;
    end else begin
      if (idle || rise || fall) begin
        tmr_reg <= HALF_LOAD;
      end else if (!tick) begin
        tmr_reg <= tmr_reg - 8'h01;
      end
      if (idle) begin
        cnt_reg <= 4'h0;
      end else if (rise) begin
        cnt_reg <= cnt_reg + 4'h1;
      end
    end
  end

  always_comb begin
    sh_next = sh_reg;
    if (wr_data && wr_ok) begin
      sh_next = bus.wdata;
    end else if (auto_go) begin
      sh_next = 8'h00;
    end else if (is_master ? fall : rise) begin
      // A master shifts in at its own fall, when the synchronised line shows the rise.
      sh_next = {sh_reg[6:0], pin_lvl_reg[`SDRWO_PIN_SDI]};
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sh_reg <= 8'h00;
      out_reg <= 1'b0;
    end else begin
      sh_reg <= sh_next;
      if (idle || fall || (wr_data && wr_ok)) begin
        out_reg <= sh_next[7];
      end
    end
  end

  // A set from a finished byte wins over any clear in the same cycle.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rx_done_reg <= 1'b0;
      tx_done_reg <= 1'b0;
      ovf_reg <= 1'b0;
    end else begin
      if (done) begin
        rx_done_reg <= 1'b1;
      end else if (rd_data || (wr_stat && bus.wdata[`SDRWO_STAT_RX])) begin
        rx_done_reg <= 1'b0;
      end
      if (done) begin
        tx_done_reg <= 1'b1;
      end else if (wr_data || (wr_stat && bus.wdata[`SDRWO_STAT_TX])) begin
        tx_done_reg <= 1'b0;
      end
      if (done && !is_master && rx_done_reg && !rd_data) begin
        ovf_reg <= 1'b1;
      end else if (wr_stat && bus.wdata[`SDRWO_STAT_OVF]) begin
        ovf_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      flag_prev_reg <= 3'h0;
    end else begin
      flag_prev_reg <= {ovf_reg, tx_done_reg, rx_done_reg};
    end
  end

  // Requests are one-cycle pulses on a flag's rising edge, only in DMA mode.
  assign bus.rx_done_req = dma_mode && rx_done_reg && !flag_prev_reg[0];
  assign bus.tx_done_req = dma_mode && tx_done_reg && !flag_prev_reg[1];
  assign bus.error_req = dma_mode && !is_master && ctrl_reg[`SDRWO_CTRL_AUTO]
                         && ovf_reg && !flag_prev_reg[2];

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_reg <= 8'h00;
    end else if (bus.rd) begin
      unique case (bus.addr)
        `SDRWO_REG_DATA: rdata_reg <= sh_reg;
        `SDRWO_REG_STAT: rdata_reg <= {4'h0, !idle, ovf_reg, tx_done_reg, rx_done_reg};
        `SDRWO_REG_CTRL: rdata_reg <= {4'h0, ctrl_reg};
        default: rdata_reg <= 8'h00;
      endcase
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  assign bus.rdata = rdata_reg;
  assign sck_out = sck_reg;
  assign sck_oe_out = en && is_master;
  assign sdo_out = out_reg;

endmodule

// File: include/sdrwo_consts.svh
// Register offsets, field positions, reset values and timing for the serial port and DMA ends.
`ifndef SDRWO_CONSTS_SVH
`define SDRWO_CONSTS_SVH
`define SDRWO_CLK_NS 50
`define SDRWO_SCK_HALF_NS 200
`define SDRWO_BITS 4'h8
`define SDRWO_REG_DATA 2'h0
`define SDRWO_REG_STAT 2'h1
`define SDRWO_REG_CTRL 2'h2
`define SDRWO_CTRL_EN 0
`define SDRWO_CTRL_MASTER 1
`define SDRWO_CTRL_AUTO 2
`define SDRWO_CTRL_DMA 3
`define SDRWO_STAT_RX 0
`define SDRWO_STAT_TX 1
`define SDRWO_STAT_OVF 2
`define SDRWO_STAT_BUSY 3
`define SDRWO_PIN_SCK 0
`define SDRWO_PIN_SDI 1
`define SDRWO_PIN_SSN 2
`define SDRWO_PIN_RST 3'h4
`define SDRWO_HREG_CTRL 3'h0
`define SDRWO_HREG_COUNT 3'h1
`define SDRWO_HREG_STAT 3'h2
`define SDRWO_HREG_CLR 3'h3
`define SDRWO_HREG_IEN 3'h4
`define SDRWO_HREG_PTR 3'h5
`define SDRWO_HREG_MEM 3'h6
`define SDRWO_HCTRL_START 0
`define SDRWO_HCTRL_WO 1
`define SDRWO_HCTRL_MASTER 2
`define SDRWO_HCTRL_BUSY 7
`define SDRWO_HSTAT_DONE 0
`define SDRWO_HSTAT_ERR 1
`endif

// File: include/sdrwo_if.sv
// Register access and DMA request signals between the serial port and the DMA end.
`timescale 1ns/1ps
interface sdrwo_if;
  import sdrwo_pkg::*;
  sdrwo_addr_type addr;
  sdrwo_byte_type wdata;
  logic wr;
  logic rd;
  sdrwo_byte_type rdata;
  logic rx_done_req;
  logic tx_done_req;
  logic error_req;
  modport dev (
    input addr, wdata, wr, rd,
    output rdata, rx_done_req, tx_done_req, error_req
  );
  modport dma (
    output addr, wdata, wr, rd,
    input rdata, rx_done_req, tx_done_req, error_req
  );
endinterface

// File: include/sdrwo_pkg.sv
// Types shared by the serial port end, the DMA end and their interface.
package sdrwo_pkg;
  typedef logic [1:0] sdrwo_addr_type;
  typedef logic [7:0] sdrwo_byte_type;
  typedef enum logic [1:0] {
    SDRWO_ST_IDLE = 2'h0,
    SDRWO_ST_LOW = 2'h1,
    SDRWO_ST_HIGH = 2'h3
  } sdrwo_port_st_type;
  typedef enum logic [2:0] {
    SDRWO_DS_IDLE = 3'h0,
    SDRWO_DS_CFG = 3'h1,
    SDRWO_DS_KICK = 3'h3,
    SDRWO_DS_WAIT = 3'h2,
    SDRWO_DS_RD = 3'h6,
    SDRWO_DS_CAP = 3'h7
  } sdrwo_dma_st_type;
endpackage

// File: sim/sdrwo_link_chk.sv
// Checker on the register strobes and DMA requests between the port and the DMA end.
`timescale 1ns/1ps
`include "sdrwo_consts.svh"
module sdrwo_link_chk
  import sdrwo_pkg::*;
(
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire sdrwo_addr_type addr,
  input wire sdrwo_byte_type wdata,
  input wire logic wr,
  input wire logic rd,
  input wire sdrwo_byte_type rdata,
  input wire logic rx_done_req,
  input wire logic tx_done_req,
  input wire logic error_req
);
  logic [7:0] cfg_reg;
  logic rx_seen_reg;
  logic tx_seen_reg;
  wire data_rd = rd && addr == `SDRWO_REG_DATA;
  wire data_wr = wr && addr == `SDRWO_REG_DATA;
  wire stat_wr = wr && addr == `SDRWO_REG_STAT;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cfg_reg <= 8'h00;
    end else if (wr && addr == `SDRWO_REG_CTRL) begin
      cfg_reg <= wdata;
    end
  end
  // Each flag is known set once its request fired, until an access clears it.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rx_seen_reg <= 1'b0;
      tx_seen_reg <= 1'b0;
    end else begin
      if (data_rd || (stat_wr && wdata[`SDRWO_STAT_RX])) begin
        rx_seen_reg <= 1'b0;
      end else if (rx_done_req) begin
        rx_seen_reg <= 1'b1;
      end
      if (data_wr || (stat_wr && wdata[`SDRWO_STAT_TX])) begin
        tx_seen_reg <= 1'b0;
      end else if (tx_done_req) begin
        tx_seen_reg <= 1'b1;
      end
    end
  end
  wire master_on = cfg_reg[`SDRWO_CTRL_EN] && cfg_reg[`SDRWO_CTRL_MASTER]
                   && cfg_reg[`SDRWO_CTRL_DMA];
  sequence s_master_write;
    data_wr && master_on;
  endsequence
  sequence s_auto_read;
    data_rd && master_on && cfg_reg[`SDRWO_CTRL_AUTO];
  endsequence
  sequence s_byte_time(logic req);
    ##[60:72] req;
  endsequence
  AST_RX_PULSE: assert property (rx_done_req |=> !rx_done_req)
    else $error("receive request wider than one cycle");
  AST_TX_PULSE: assert property (tx_done_req |=> !tx_done_req)
    else $error("transmit request wider than one cycle");
  AST_RX_EDGE: assert property (rx_done_req |-> !rx_seen_reg)
    else $error("receive request while flag still set");
  AST_TX_EDGE: assert property (tx_done_req |-> !tx_seen_reg)
    else $error("transmit request while flag still set");
  AST_RX_BOTH: assert property (rx_done_req |-> tx_done_req || tx_seen_reg)
    else $error("receive done without transmit done");
  AST_TX_BOTH: assert property (tx_done_req |-> rx_done_req || rx_seen_reg)
    else $error("transmit done without receive done");
  AST_WR_START: assert property (s_master_write |-> s_byte_time(tx_done_req))
    else $error("data write did not run one byte");
  AST_AUTO_SHIFT: assert property (s_auto_read |-> s_byte_time(rx_done_req))
    else $error("auto read did not run one byte");
endmodule

// File: sim/tb_spi_dma_read_write_only.sv
// Bench joining the serial port and the DMA end, with a byte model and a wire monitor.
`timescale 1ns/1ps
`include "sdrwo_consts.svh"
module tb_spi_dma_read_write_only;
  import sdrwo_pkg::*;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [2:0] sw_addr = 3'h0;
  logic [7:0] sw_wdata = 8'h00;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic [7:0] sw_rdata;
  logic irq;
  logic link_sck = 1'b0;
  logic slv_sdi = 1'b0;
  logic ss_n = 1'b1;
  logic sck_out;
  logic sck_oe;
  logic sdo;
  logic master_mode = 1'b0;
  logic wo_mode = 1'b0;
  logic sck_d = 1'b0;
  logic [7:0] sh = 8'h00;
  int nb;
  int wire_cnt;
  int mismatches;
  int n_checks;
  logic [7:0] exp_q[$];
  wire sck_w = sck_oe ? sck_out : link_sck;
  // A master hears its own data inverted, so shifted zeros come back as ones.
  wire sdi_w = master_mode ? ~sdo : slv_sdi;
  sdrwo_if link_if();
  sdrwo_port u_sdrwo_port (.clk_in(clk_in), .nrst_in(nrst_in), .bus(link_if.dev),
    .sck_in(sck_w), .sck_out(sck_out), .sck_oe_out(sck_oe), .sdi_in(sdi_w),
    .sdo_out(sdo), .ss_n_in(ss_n));
  sdrwo_dma u_sdrwo_dma (.clk_in(clk_in), .nrst_in(nrst_in), .bus(link_if.dma),
    .sw_addr_in(sw_addr), .sw_wdata_in(sw_wdata), .sw_wr_in(sw_wr), .sw_rd_in(sw_rd),
    .sw_rdata_out(sw_rdata), .irq_out(irq));
  sdrwo_link_chk u_chk (.clk_in(clk_in), .nrst_in(nrst_in), .addr(link_if.addr),
    .wdata(link_if.wdata), .wr(link_if.wr), .rd(link_if.rd), .rdata(link_if.rdata),
    .rx_done_req(link_if.rx_done_req), .tx_done_req(link_if.tx_done_req),
    .error_req(link_if.error_req));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] expv);
    n_checks++;
    if (seen !== expv) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, expv, seen);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic sw_write(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_in);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clk_in);
    sw_wr <= 1'b0;
  endtask
  task automatic sw_read(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_in);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clk_in);
    sw_rd <= 1'b0;
    #1 d = sw_rdata;
  endtask
  // Plays an outside master: data set up before each rise, clock still between frames.
  task automatic slave_send(input logic [7:0] q[$]);
    repeat (10) @(posedge clk_in);
    ss_n <= 1'b0;
    repeat (4) @(posedge clk_in);
    foreach (q[b]) begin
      for (int k = 7; k >= 0; k--) begin
        slv_sdi <= ~q[b][k];
        repeat (4) @(posedge clk_in);
        link_sck <= 1'b1;
        repeat (4) @(posedge clk_in);
        link_sck <= 1'b0;
      end
    end
    repeat (4) @(posedge clk_in);
    slv_sdi <= ~slv_sdi;
    ss_n <= 1'b1;
  endtask
  // Rebuilds each byte from the data line at every rise of the link clock in master mode.
  always @(negedge clk_in) begin
    sck_d <= sck_w;
    if (master_mode && sck_w && !sck_d) begin
      sh = {sh[6:0], sdo};
      nb++;
      if (nb == 8) begin
        nb = 0;
        wire_cnt++;
        check("wire byte", sh, wo_mode ? exp_q.pop_front() : 8'h00);
      end
    end
  end
  task automatic run_block(input logic wo, input logic mst, input logic ien, input int n);
    logic [7:0] d;
    logic [7:0] q[$];
    int i;
    @(posedge clk_in);
    nrst_in <= 1'b0;
    master_mode <= mst;
    wo_mode <= wo;
    repeat (3) @(posedge clk_in);
    nrst_in <= 1'b1;
    nb = 0;
    wire_cnt = 0;
    exp_q = {};
    sw_write(`SDRWO_HREG_PTR, 8'h00);
    for (i = 0; i < n; i++) begin
      d = 8'($urandom);
      q.push_back(d);
      if (wo) exp_q.push_back(d);
      sw_write(`SDRWO_HREG_MEM, d);
    end
    sw_write(3'h7, 8'hff);
    sw_write(`SDRWO_HREG_COUNT, 8'(n));
    sw_write(`SDRWO_HREG_IEN, {7'h00, ien});
    sw_write(`SDRWO_HREG_CTRL, {5'h00, mst, wo, 1'b1});
    if (!mst) slave_send(q);
    i = 0;
    d = 8'h00;
    while (!d[0] && i < 400) begin
      sw_read(`SDRWO_HREG_STAT, d);
      i++;
    end
    check("block done", d[0], 1'b1);
    check("irq level", irq, ien);
    check("pin drive enable", sck_oe, mst);
    if (wo) begin
      check("bytes on wire", 8'(wire_cnt), 8'(n));
      check("clock idle", sck_w, 1'b0);
    end else begin
      for (i = 0; i < n; i++) begin
        sw_write(`SDRWO_HREG_PTR, 8'(i));
        sw_read(`SDRWO_HREG_MEM, d);
        check("stored byte", d, mst ? 8'hff : ~q[i]);
      end
    end
    sw_write(`SDRWO_HREG_CLR, 8'h03);
    sw_read(`SDRWO_HREG_STAT, d);
    check("status cleared", d[1:0], 2'h0);
    check("irq cleared", irq, 1'b0);
  endtask
  initial begin
    forever #25 clk_in = ~clk_in;
  end
  initial begin
    #1000000;
    mismatches++;
    close_out();
  end
  initial begin
    logic [7:0] d;
    void'($urandom(11));
    repeat (3) @(posedge clk_in);
    nrst_in <= 1'b1;
    sw_write(`SDRWO_HREG_COUNT, 8'h00);
    sw_write(`SDRWO_HREG_CTRL, 8'h05);
    sw_read(`SDRWO_HREG_CTRL, d);
    check("start refused", d[7], 1'b0);
    run_block(1'b0, 1'b1, 1'b1, 5);
    run_block(1'b1, 1'b1, 1'b1, 5);
    run_block(1'b0, 1'b0, 1'b0, 3);
    close_out();
  end
endmodule
